// ### ubs_cfg.svh
// Constants of the break, sync and clocked master transmit block
`ifndef UBS_CFG_SVH
`define UBS_CFG_SVH

// Character lengths in bits and index of the last received data bit
`define UBS_DATA_BITS       4'h8
`define UBS_NINTH_BITS      4'h9
`define UBS_BREAK_ZERO_BITS 4'hc
`define UBS_RX_LAST_BIT     4'h7

// Reset values
`define UBS_DIV_RESET       16'h0000
`define UBS_SHIFT_RESET     9'h000
`define UBS_BYTE_RESET      8'h00
`define UBS_CNT_RESET       4'h0

`endif

// ### ubs_pkg.sv
// Types shared by the break, sync and clocked master transmit block
package ubs_pkg;

    // Configuration levels set by software
    typedef struct packed {
        logic        clockedModeSelect;
        logic        clockSourceMaster;
        logic        singleReceiveEnable;
        logic        continuousReceiveEnable;
        logic        portEnable;
        logic        transmitEnable;
        logic        clockIdlePolarity;
        logic        dataInvert;
        logic        ninthBitEnable;
        logic        ninthBitValue;
        logic [15:0] baudDivisor;
    } ubs_cfg_s;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubs_tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubs_rx_state_e;

endpackage

// ### ubs_half_tick.sv
// Half-bit tick generator driven by the baud divisor
`timescale 1ns/1ps
`default_nettype none
`include "ubs_cfg.svh"

module ubs_half_tick (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        restart,
    input  wire logic [15:0] divisor,
    // Tick, one cycle every divisor+1 cycles
    output logic             tick
);

    logic [15:0] cntReg;
    logic [15:0] cntNext;
    logic        tickNext;

    // Tick stands while the count is zero, so the first half bit is full length
    always_comb begin
        if (restart || cntReg == 16'h0000) begin
            cntNext = divisor;
        end else begin
            cntNext = cntReg - 16'h0001;
        end
        tickNext = (cntNext == 16'h0000);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cntReg <= `UBS_DIV_RESET;
            tick   <= 1'b0;
        end else begin
            cntReg <= cntNext;
            tick   <= tickNext;
        end
    end

endmodule
`default_nettype wire

// ### ubs_break_sync_tx.sv
// Break and sync transmit, break receive and clocked master transmit
//
// Contract
// - Break request plus write sends a break
// - Break request self-clears, queued byte follows
// - Holding empty flag rises when holding empties
// - Received break: ready, framing error, zero data
// - Wake mode: edge flags ready, then byte
// - Clocked mode shifts data bits only
// - Clocked mode is half-duplex on two lines
// - Mode, master, direction and enable bits decode
// - Master drives clock pin, driver auto-enabled
// - One clock per data bit, no extra
// - Idle polarity sets clock level and edges
// - Master transmit drives data and clock pins
// - Holding waits for shifter, else moves at once
// - Data changes on leading clock edge
// - Data invert flips transmit and receive data
// - Ninth bit enable shifts nine bits
// - Shift register is not software visible
// - Break is start, twelve zeros, stop
// - Shift empty shows transmit activity
`timescale 1ns/1ps
`default_nettype none
`include "ubs_cfg.svh"

module ubs_break_sync_tx (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Configuration
    input  wire ubs_pkg::ubs_cfg_s cfg,
    // Software strobes
    input  wire logic             sendBreakSet,
    input  wire logic             wakeOnEdgeSet,
    input  wire logic             txWrite,
    input  wire logic [7:0]       txWriteData,
    input  wire logic             rxRead,
    // Status
    output logic                  sendBreakRequest,
    output logic                  wakeOnEdgeEnable,
    output logic                  txBufferEmptyFlag,
    output logic                  txShiftEmpty,
    output logic                  rxReadyFlag,
    output logic                  framingErrorFlag,
    output logic [7:0]            rxData,
    // Pins
    input  wire logic             dataPinIn,
    output logic                  dataPinOut,
    output logic                  dataPinOe,
    output logic                  clockPinOut,
    output logic                  clockPinOe
);

    ubs_pkg::ubs_tx_state_e txState, txStateNext;
    ubs_pkg::ubs_rx_state_e rxState, rxStateNext;
    logic [8:0] holdReg, holdNext, shiftReg, shiftNext;
    logic [3:0] bitCntReg, bitCntNext, rxCntReg, rxCntNext;
    logic [7:0] rxShiftReg, rxShiftNext, rxDataNext;
    logic       halfReg, halfNext, breakReg, breakNext, lineReg, lineNext;
    logic       clkReg, clkNext, emptyNext, sbNext, trmtNext;
    logic       clkOutNext, clkOeNext, datOutNext, datOeNext;
    logic       txRestart, txTick, rxRestart, rxTick;
    logic       rxSync1Reg, rxSync2Reg, rxPrevReg, rxLine, rxFall, rxRise;
    logic       rxHalfReg, rxHalfNext, readyNext, ferrNext, wakeNext;
    logic       txActive, txMode, rxEnable, clkIdle;
    logic [3:0] charBits;

    ubs_half_tick txTicker (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .restart (txRestart),
        .divisor (cfg.baudDivisor),
        .tick    (txTick)
    );

    ubs_half_tick rxTicker (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .restart (rxRestart),
        .divisor (cfg.baudDivisor),
        .tick    (rxTick)
    );

    assign txActive = cfg.portEnable && cfg.transmitEnable;
    assign txMode   = !cfg.singleReceiveEnable && !cfg.continuousReceiveEnable;
    assign clkIdle  = cfg.clockIdlePolarity;
    assign charBits = cfg.ninthBitEnable ? `UBS_NINTH_BITS : `UBS_DATA_BITS;

    // Transmit path
    always_comb begin
        txStateNext = txState;
        holdNext    = holdReg;
        emptyNext   = txBufferEmptyFlag;
        shiftNext   = shiftReg;
        bitCntNext  = bitCntReg;
        halfNext    = halfReg;
        breakNext   = breakReg;
        lineNext    = lineReg;
        clkNext     = clkReg;
        sbNext      = sendBreakRequest;
        txRestart   = 1'b0;
        case (txState)
            ubs_pkg::TX_IDLE: begin
                lineNext = 1'b1;
                clkNext  = clkIdle;
                if (!txBufferEmptyFlag && txActive
                    && (!cfg.clockedModeSelect || (cfg.clockSourceMaster && txMode))) begin
                    shiftNext  = holdReg;
                    emptyNext  = 1'b1;
                    halfNext   = 1'b0;
                    txRestart  = 1'b1;
                    bitCntNext = charBits;
                    if (cfg.clockedModeSelect) begin
                        txStateNext = ubs_pkg::TX_DATA;
                        breakNext   = 1'b0;
                        lineNext    = holdReg[0];
                        clkNext     = !clkIdle;
                    end else begin
                        txStateNext = ubs_pkg::TX_START;
                        breakNext   = sendBreakRequest;
                        lineNext    = 1'b0;
                        if (sendBreakRequest) begin
                            bitCntNext = `UBS_BREAK_ZERO_BITS;
                        end
                    end
                end
            end
            ubs_pkg::TX_START: begin
                if (txTick) begin
                    halfNext = !halfReg;
                    if (halfReg) begin
                        txStateNext = ubs_pkg::TX_DATA;
                        lineNext    = breakReg ? 1'b0 : shiftReg[0];
                    end
                end
            end
            ubs_pkg::TX_DATA: begin
                if (txTick) begin
                    halfNext = !halfReg;
                    if (!halfReg) begin
                        clkNext = clkIdle;
                    end else begin
                        shiftNext  = {1'b0, shiftReg[8:1]};
                        bitCntNext = bitCntReg - 4'h1;
                        if (bitCntReg == 4'h1) begin
                            txStateNext = cfg.clockedModeSelect ? ubs_pkg::TX_IDLE
                                                                : ubs_pkg::TX_STOP;
                            lineNext    = 1'b1;
                        end else begin
                            lineNext = breakReg ? 1'b0 : shiftReg[1];
                            clkNext  = cfg.clockedModeSelect ? !clkIdle : clkIdle;
                        end
                    end
                end
            end
            ubs_pkg::TX_STOP: begin
                lineNext = 1'b1;
                if (txTick) begin
                    halfNext = !halfReg;
                    if (halfReg) begin
                        txStateNext = ubs_pkg::TX_IDLE;
                        breakNext   = 1'b0;
                        if (breakReg) begin
                            sbNext = 1'b0;
                        end
                    end
                end
            end
            default: begin
                txStateNext = ubs_pkg::TX_IDLE;
            end
        endcase
        if (!cfg.portEnable) begin
            txStateNext = ubs_pkg::TX_IDLE;
            lineNext    = 1'b1;
            clkNext     = clkIdle;
        end
        if (txWrite && cfg.transmitEnable) begin
            holdNext  = {cfg.ninthBitValue, txWriteData};
            emptyNext = 1'b0;
        end
        if (sendBreakSet) begin
            sbNext = 1'b1;
        end
        trmtNext   = (txStateNext == ubs_pkg::TX_IDLE);
        clkOutNext = cfg.clockedModeSelect ? clkNext : (lineNext ^ cfg.dataInvert);
        clkOeNext  = cfg.portEnable
                     && (cfg.clockedModeSelect ? cfg.clockSourceMaster : cfg.transmitEnable);
        datOutNext = lineNext ^ cfg.dataInvert;
        datOeNext  = txActive && cfg.clockedModeSelect && cfg.clockSourceMaster && txMode;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txState           <= ubs_pkg::TX_IDLE;
            holdReg           <= `UBS_SHIFT_RESET;
            txBufferEmptyFlag <= 1'b1;
            shiftReg          <= `UBS_SHIFT_RESET;
            bitCntReg         <= `UBS_CNT_RESET;
            halfReg           <= 1'b0;
            breakReg          <= 1'b0;
            lineReg           <= 1'b1;
            clkReg            <= 1'b0;
            sendBreakRequest  <= 1'b0;
            txShiftEmpty      <= 1'b1;
            clockPinOut       <= 1'b0;
            clockPinOe        <= 1'b0;
            dataPinOut        <= 1'b1;
            dataPinOe         <= 1'b0;
        end else begin
            txState           <= txStateNext;
            holdReg           <= holdNext;
            txBufferEmptyFlag <= emptyNext;
            shiftReg          <= shiftNext;
            bitCntReg         <= bitCntNext;
            halfReg           <= halfNext;
            breakReg          <= breakNext;
            lineReg           <= lineNext;
            clkReg            <= clkNext;
            sendBreakRequest  <= sbNext;
            txShiftEmpty      <= trmtNext;
            clockPinOut       <= clkOutNext;
            clockPinOe        <= clkOeNext;
            dataPinOut        <= datOutNext;
            dataPinOe         <= datOeNext;
        end
    end

    // Receive path, asynchronous only
    assign rxLine   = rxSync2Reg ^ cfg.dataInvert;
    assign rxFall   = rxPrevReg && !rxLine;
    assign rxRise   = !rxPrevReg && rxLine;
    assign rxEnable = cfg.portEnable && !cfg.clockedModeSelect && cfg.continuousReceiveEnable;

    always_comb begin
        rxStateNext = rxState;
        rxShiftNext = rxShiftReg;
        rxCntNext   = rxCntReg;
        rxHalfNext  = rxHalfReg;
        rxDataNext  = rxData;
        ferrNext    = framingErrorFlag;
        wakeNext    = wakeOnEdgeEnable;
        rxRestart   = 1'b0;
        readyNext   = rxRead ? 1'b0 : rxReadyFlag;
        case (rxState)
            ubs_pkg::RX_IDLE: begin
                if (wakeOnEdgeEnable) begin
                    if (rxFall) begin
                        readyNext = 1'b1;
                    end
                    if (rxRise) begin
                        wakeNext = 1'b0;
                    end
                end else if (rxEnable && rxFall) begin
                    rxStateNext = ubs_pkg::RX_START;
                    rxRestart   = 1'b1;
                end
            end
            ubs_pkg::RX_START: begin
                if (rxTick) begin
                    rxStateNext = rxLine ? ubs_pkg::RX_IDLE : ubs_pkg::RX_DATA;
                    rxCntNext   = `UBS_CNT_RESET;
                    rxHalfNext  = 1'b0;
                end
            end
            ubs_pkg::RX_DATA: begin
                if (rxTick) begin
                    rxHalfNext = !rxHalfReg;
                    if (rxHalfReg) begin
                        rxShiftNext = {rxLine, rxShiftReg[7:1]};
                        rxCntNext   = rxCntReg + 4'h1;
                        if (rxCntReg == `UBS_RX_LAST_BIT) begin
                            rxStateNext = ubs_pkg::RX_STOP;
                        end
                    end
                end
            end
            ubs_pkg::RX_STOP: begin
                if (rxTick) begin
                    rxHalfNext = !rxHalfReg;
                    if (rxHalfReg) begin
                        rxStateNext = ubs_pkg::RX_IDLE;
                        rxDataNext  = rxShiftReg;
                        ferrNext    = !rxLine;
                        readyNext   = 1'b1;
                    end
                end
            end
            default: begin
                rxStateNext = ubs_pkg::RX_IDLE;
            end
        endcase
        if (!rxEnable) begin
            rxStateNext = ubs_pkg::RX_IDLE;
        end
        if (wakeOnEdgeSet) begin
            wakeNext = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rxSync1Reg       <= 1'b1;
            rxSync2Reg       <= 1'b1;
            rxPrevReg        <= 1'b1;
            rxState          <= ubs_pkg::RX_IDLE;
            rxShiftReg       <= `UBS_BYTE_RESET;
            rxCntReg         <= `UBS_CNT_RESET;
            rxHalfReg        <= 1'b0;
            rxData           <= `UBS_BYTE_RESET;
            rxReadyFlag      <= 1'b0;
            framingErrorFlag <= 1'b0;
            wakeOnEdgeEnable <= 1'b0;
        end else begin
            rxSync1Reg       <= dataPinIn;
            rxSync2Reg       <= rxSync1Reg;
            rxPrevReg        <= rxLine;
            rxState          <= rxStateNext;
            rxShiftReg       <= rxShiftNext;
            rxCntReg         <= rxCntNext;
            rxHalfReg        <= rxHalfNext;
            rxData           <= rxDataNext;
            rxReadyFlag      <= readyNext;
            framingErrorFlag <= ferrNext;
            wakeOnEdgeEnable <= wakeNext;
        end
    end

    // Checks
    // Leading clock edges of the current character, restarted from idle
    logic [3:0] leadCntReg;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            leadCntReg <= `UBS_CNT_RESET;
        end else if (cfg.clockedModeSelect
                     && clkOutNext != clkIdle && clockPinOut == clkIdle) begin
            leadCntReg <= txShiftEmpty ? 4'h1 : leadCntReg + 4'h1;
        end else if (txShiftEmpty) begin
            leadCntReg <= `UBS_CNT_RESET;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_break_zero_line;
        breakReg && txState == ubs_pkg::TX_DATA |-> clockPinOut == cfg.dataInvert;
    endproperty
    a_break_zero_line: assert property (p_break_zero_line) else $error("break bit not zero");
    property p_break_len;
        $rose(txState == ubs_pkg::TX_START) && breakNext |=> bitCntReg == `UBS_BREAK_ZERO_BITS;
    endproperty
    a_break_len: assert property (p_break_len) else $error("break length wrong");
    property p_break_clear;
        $fell(sendBreakRequest) |-> $past(txState) == ubs_pkg::TX_STOP && txShiftEmpty;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break request cleared early");
    property p_hold_full;
        txWrite && cfg.transmitEnable |=> !txBufferEmptyFlag;
    endproperty
    a_hold_full: assert property (p_hold_full) else $error("holding empty after write");
    property p_framing_error_flag_ready;
        $rose(framingErrorFlag) |-> rxReadyFlag;
    endproperty
    a_framing_error_flag_ready: assert property (p_framing_error_flag_ready) else $error("framing error without ready");
    property p_wake_edge;
        wakeOnEdgeEnable && rxState == ubs_pkg::RX_IDLE && rxFall && !rxRead |=> rxReadyFlag;
    endproperty
    a_wake_edge: assert property (p_wake_edge) else $error("wake edge not flagged");
    property p_clock_count;
        cfg.clockedModeSelect && $rose(txShiftEmpty) |-> leadCntReg == charBits;
    endproperty
    a_clock_count: assert property (p_clock_count) else $error("wrong clock count");
    property p_clock_idle;
        cfg.clockedModeSelect && $past(cfg.clockedModeSelect) && $stable(clkIdle)
            && txShiftEmpty && $past(txShiftEmpty, 2) |-> clockPinOut == clkIdle;
    endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("clock not idle");
    property p_data_lead;
        cfg.clockedModeSelect && !txShiftEmpty && $changed(dataPinOut) |-> clockPinOut != clkIdle;
    endproperty
    a_data_lead: assert property (p_data_lead) else $error("data moved off leading edge");
    property p_half_duplex;
        dataPinOe |-> $past(cfg.clockedModeSelect && txMode && cfg.clockSourceMaster);
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("data driven outside transmit");

    c_break_done: cover property ($fell(sendBreakRequest));
    c_rx_break: cover property ($rose(framingErrorFlag) && rxDataNext == 8'h00);
    c_wake: cover property ($fell(wakeOnEdgeEnable));
    c_sync_char: cover property (cfg.clockedModeSelect && $rose(txShiftEmpty));

endmodule
`default_nettype wire

// ### ubs_line_node.sv
// Far-side model: pulled-up line node, character decoder and clocked slave
`timescale 1ns/1ps
`default_nettype none

module ubs_line_node #(
    parameter int BIT_CYC = 16,
    parameter int BIT_NS  = 125
) (
    // Clock, reset and clear
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    // Lines from the design
    input  wire logic       txLine,
    input  wire logic       ckOe,
    input  wire logic       dtWire,
    input  wire logic       ckPol,
    // Line into the design
    output logic            rxLine,
    // Observations
    output logic [7:0]      gotByte,
    output logic            gotFerr,
    output logic [3:0]      gotCount,
    output logic [9:0]      maxLow,
    output logic [8:0]      slvShift,
    output logic [4:0]      slvEdges
);
    logic       busy;
    logic       armed;
    logic       prevCk;
    logic [7:0] sh;
    logic [9:0] lowRun;
    int         t;

    // Released line rests at the pull-up level
    initial rxLine = 1'b1;

    task automatic drive(input logic v, input int n);
        rxLine = v;
        #(n * BIT_NS);
    endtask

    task automatic sendByte(input logic [7:0] b);
        drive(1'b0, 1);
        for (int i = 0; i < 8; i++) drive(b[i], 1);
        drive(1'b1, 2);
    endtask

    always @(posedge mclk) begin
        prevCk <= txLine;
        if (!rst_n || clr) begin
            {busy, armed, gotCount, maxLow, lowRun, slvEdges, slvShift} <= '0;
            t <= 0;
        end else begin
            lowRun <= txLine ? 10'h000 : lowRun + 10'h001;
            if (!txLine && lowRun >= maxLow) maxLow <= lowRun + 10'h001;
            // Slave takes data on the edge that returns the clock to idle
            if (ckOe && prevCk !== txLine && txLine === ckPol) begin
                slvShift <= {dtWire, slvShift[8:1]};
                slvEdges <= slvEdges + 5'h01;
            end
            // Re-arm only after the line has been high, so a long low is one character
            if (!busy) begin
                armed <= armed | txLine;
                busy  <= armed & !txLine;
                t     <= 0;
            end else begin
                t <= t + 1;
                if (t % BIT_CYC == BIT_CYC / 2 && t > BIT_CYC) begin
                    if (t < 9 * BIT_CYC) begin
                        sh <= {txLine, sh[7:1]};
                    end else begin
                        gotByte  <= sh;
                        gotFerr  <= !txLine;
                        gotCount <= gotCount + 4'h1;
                        busy     <= 1'b0;
                        armed    <= 1'b0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for break, sync, break receive and clocked master transmit
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic              mclk;
    logic              rst_n;
    ubs_pkg::ubs_cfg_s cfg;
    logic              sendBreakSet;
    logic              wakeOnEdgeSet;
    logic              txWrite;
    logic [7:0]        txWriteData;
    logic              rxRead;
    logic              clr;
    logic              sendBreakRequest;
    logic              wakeOnEdgeEnable;
    logic              txBufferEmptyFlag;
    logic              txShiftEmpty;
    logic              rxReadyFlag;
    logic              framingErrorFlag;
    logic [7:0]        rxData;
    logic              dataPinOut;
    logic              dataPinOe;
    logic              clockPinOut;
    logic              clockPinOe;
    logic              nodeLine;
    logic [7:0]        gotByte;
    logic              gotFerr;
    logic [3:0]        gotCount;
    logic [9:0]        maxLow;
    logic [8:0]        slvShift;
    logic [4:0]        slvEdges;
    int                fails;
    int                checks_done;
    wire logic         dataWire = dataPinOe ? dataPinOut : nodeLine;

    ubs_break_sync_tx ubs_break_sync_tx_i (
        .mclk(mclk), .rst_n(rst_n), .cfg(cfg), .sendBreakSet(sendBreakSet),
        .wakeOnEdgeSet(wakeOnEdgeSet), .txWrite(txWrite), .txWriteData(txWriteData),
        .rxRead(rxRead), .sendBreakRequest(sendBreakRequest),
        .wakeOnEdgeEnable(wakeOnEdgeEnable), .txBufferEmptyFlag(txBufferEmptyFlag),
        .txShiftEmpty(txShiftEmpty), .rxReadyFlag(rxReadyFlag),
        .framingErrorFlag(framingErrorFlag), .rxData(rxData), .dataPinIn(dataWire),
        .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .clockPinOut(clockPinOut),
        .clockPinOe(clockPinOe));

    ubs_line_node ubs_line_node_i (
        .mclk(mclk), .rst_n(rst_n), .clr(clr), .txLine(clockPinOut), .ckOe(clockPinOe),
        .dtWire(dataWire), .ckPol(cfg.clockIdlePolarity), .rxLine(nodeLine),
        .gotByte(gotByte), .gotFerr(gotFerr), .gotCount(gotCount), .maxLow(maxLow),
        .slvShift(slvShift), .slvEdges(slvEdges));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] b);
        @(negedge mclk);
        txWriteData = b;
        txWrite = 1'b1;
        @(negedge mclk);
        txWrite = 1'b0;
    endtask

    // One-cycle strobe: 3 break set, 2 wake set, 1 read, 0 model clear
    task automatic strobe(input int s);
        @(negedge mclk);
        {sendBreakSet, wakeOnEdgeSet, rxRead, clr} = 4'h1 << s;
        @(negedge mclk);
        {sendBreakSet, wakeOnEdgeSet, rxRead, clr} = 4'h0;
    endtask

    task automatic setCfg(input ubs_pkg::ubs_cfg_s c);
        @(negedge mclk);
        cfg = c;
        cyc(3);
        strobe(0);
    endtask

    task automatic waitIdle;
        cyc(2);
        for (int k = 0; k < 5000 && txShiftEmpty !== 1'b1; k++) cyc(1);
        cyc(2);
    endtask

    task automatic waitCnt(input logic [3:0] n);
        for (int k = 0; k < 5000 && gotCount !== n; k++) cyc(1);
    endtask

    task automatic waitReady;
        for (int k = 0; k < 5000 && rxReadyFlag !== 1'b1; k++) cyc(1);
    endtask

    initial begin
        #400000;
        fails++;
        wrap_up;
    end

    initial begin
        ubs_pkg::ubs_cfg_s c;
        logic [8:0]        e;
        rst_n = 1'b0;
        cfg = '0;
        {sendBreakSet, wakeOnEdgeSet, rxRead, clr, txWrite} = 5'h00;
        txWriteData = 8'h00;
        fails = 0;
        checks_done = 0;
        cyc(3);
        rst_n = 1'b1;
        check("emptyFlag", txBufferEmptyFlag, 1'b1);
        check("shiftEmpty", txShiftEmpty, 1'b1);
        c = '0;
        c.portEnable = 1'b1;
        c.transmitEnable = 1'b1;
        c.baudDivisor = 16'h0007;
        setCfg(c);
        strobe(3);
        wr(8'ha7);
        wr(8'h55);
        check("breakReq", sendBreakRequest, 1'b1);
        check("holdWaits", txBufferEmptyFlag, 1'b0);
        check("busy", txShiftEmpty, 1'b0);
        waitCnt(4'h1);
        check("breakByte", gotByte, 8'h00);
        check("breakStop", gotFerr, 1'b1);
        waitCnt(4'h2);
        check("syncByte", gotByte, 8'h55);
        check("breakReqClr", sendBreakRequest, 1'b0);
        check("breakLow", maxLow, 10'h0d0);
        waitIdle;
        check("emptyAfter", txBufferEmptyFlag, 1'b1);
        check("idleAfter", txShiftEmpty, 1'b1);
        c.continuousReceiveEnable = 1'b1;
        setCfg(c);
        ubs_line_node_i.drive(1'b0, 13);
        ubs_line_node_i.drive(1'b1, 2);
        waitReady;
        check("rxReady", rxReadyFlag, 1'b1);
        check("rxFerr", framingErrorFlag, 1'b1);
        check("rxBreak", rxData, 8'h00);
        strobe(1);
        check("rxCleared", rxReadyFlag, 1'b0);
        ubs_line_node_i.sendByte(8'h3c);
        waitReady;
        check("rxByte", rxData, 8'h3c);
        check("rxNoFerr", framingErrorFlag, 1'b0);
        strobe(1);
        strobe(2);
        check("wakeSet", wakeOnEdgeEnable, 1'b1);
        ubs_line_node_i.drive(1'b0, 5);
        check("wakeReady", rxReadyFlag, 1'b1);
        check("wakeHeld", wakeOnEdgeEnable, 1'b1);
        ubs_line_node_i.drive(1'b0, 8);
        ubs_line_node_i.drive(1'b1, 2);
        check("wakeClr", wakeOnEdgeEnable, 1'b0);
        strobe(1);
        ubs_line_node_i.sendByte(8'hc3);
        waitReady;
        check("wakeByte", rxData, 8'hc3);
        // Clocked master over every polarity, inversion and length
        for (int m = 0; m < 8; m++) begin
            c = '0;
            c.clockedModeSelect = 1'b1;
            c.clockSourceMaster = 1'b1;
            c.portEnable = 1'b1;
            c.transmitEnable = 1'b1;
            c.clockIdlePolarity = m[0];
            c.dataInvert = m[1];
            c.ninthBitEnable = m[2];
            c.ninthBitValue = 1'b1;
            c.baudDivisor = 16'h0007;
            setCfg(c);
            check("clockIdle", clockPinOut, m[0]);
            check("clockOe", clockPinOe, 1'b1);
            wr(8'h96 ^ m[7:0]);
            cyc(2);
            check("dataOe", dataPinOe, 1'b1);
            waitIdle;
            e = {1'b1, 8'h96 ^ m[7:0]} ^ {9{m[1]}};
            check("edges", slvEdges, m[2] ? 5'h09 : 5'h08);
            check("shifted", m[2] ? slvShift : slvShift >> 1, m[2] ? e : e & 9'h0ff);
            check("clockRest", clockPinOut, m[0]);
        end
        c.singleReceiveEnable = 1'b1;
        setCfg(c);
        wr(8'h5a);
        cyc(40);
        check("rxModeQuiet", dataPinOe, 1'b0);
        check("rxModeIdle", txShiftEmpty, 1'b1);
        c.singleReceiveEnable = 1'b0;
        c.clockSourceMaster = 1'b0;
        setCfg(c);
        check("slaveClockOe", clockPinOe, 1'b0);
        check("slaveIdle", txShiftEmpty, 1'b1);
        wrap_up;
    end
endmodule
`default_nettype wire
